// ==== rtl/sram_timing_pkg.sv ====
// Package for the single-bit static memory controller.
// Assumes a 100 MHz system clock; times are in nanoseconds.
package sram_timing_pkg;

    // ========================================================
    // Geometry
    localparam int ADDR_W = 16;

    // ========================================================
    // Clock and fastest-grade times, ns
    localparam int CLK_PERIOD_NS            = 10;
    localparam int READ_CYCLE_MIN_NS        = 25;
    localparam int ADDRESS_TO_DATA_MAX_NS   = 25;
    localparam int SELECT_TO_DATA_MAX_NS    = 25;
    localparam int DESELECT_TO_FLOAT_MAX_NS = 20;
    localparam int WRITE_CYCLE_MIN_NS       = 25;
    localparam int SELECT_TO_WRITE_END_NS   = 20;
    localparam int ADDRESS_TO_WRITE_END_NS  = 20;
    localparam int WRITE_PULSE_MIN_NS       = 20;
    localparam int DATA_TO_WRITE_END_NS     = 15;
    localparam int DATA_HOLD_MIN_NS         = 5;

    // Least times round up to whole cycles
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int READ_CYC  = cyc_up(READ_CYCLE_MIN_NS);
    localparam int ACC_CYC   = cyc_up(ADDRESS_TO_DATA_MAX_NS);
    localparam int WP_CYC    = cyc_up(WRITE_PULSE_MIN_NS);
    localparam int WC_CYC    = cyc_up(WRITE_CYCLE_MIN_NS);
    localparam int FLOAT_CYC = cyc_up(DESELECT_TO_FLOAT_MAX_NS);
    localparam int CNT_W     = 4;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_WRITE = 3'b011,
        ST_HOLD  = 3'b010,
        ST_FLOAT = 3'b110
    } sram_state_t;

endpackage : sram_timing_pkg

// ==== rtl/sram_bit_ctrl.sv ====
// Controller for a 64K x 1 asynchronous static memory.
// Assumes the memory pins are wired straight out; dout is synchronous.
//
// Overview of operation
// RL1 - sixteen address bits, separate data in/out
// RL2 - select high gives standby, output floats
// RL3 - select low, write high reads
// RL4 - select low, write low stores data
// RL5 - address changes only while strobes high
// RL6 - joint strobe rise keeps output floating
// RL7 - address valid by select falling edge
// RL8 - cycles measured address to address
// RL9 - read cycle at least 25 ns
// RL10 - data valid 25 ns after address
// RL11 - data valid 25 ns after select
// RL12 - old data held 5 ns
// RL13 - output drives 5 ns after select
// RL14 - output floats 20 ns after deselect
// RL15 - write cycle at least 25 ns
// RL16 - select low 20 ns before write end
// RL17 - address valid 20 ns before write end
// RL18 - zero address setup and recovery
// RL19 - write pulse at least 20 ns
// RL20 - data stable 15 ns before end
// RL21 - data held 5 ns after end
// RL22 - output floats 20 ns after write
// RL23 - output may drive after write ends
// RL24 - one speed grade fixed at build
`timescale 1ns/100ps
module sram_bit_ctrl
    import sram_timing_pkg::*;
(
    // Clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               rstn,
    // Request side
    input  wire logic                               req_valid,
    output logic                                    req_ready,
    input  wire logic                               req_write,
    input  wire logic [sram_timing_pkg::ADDR_W-1:0] req_addr,
    input  wire logic                               req_wdata,
    output logic                                    rsp_valid,
    output logic                                    rsp_rdata,
    // Memory pins
    output logic [sram_timing_pkg::ADDR_W-1:0]      word_address,
    output logic                                    select_n,
    output logic                                    write_en_n,
    output logic                                    data_to_mem,
    input  wire logic                               data_from_mem
);
    import sram_timing_pkg::*;

    sram_state_t            state_ff;
    logic [CNT_W-1:0]       cnt_ff;

    // Counter is on the final cycle of an n-cycle phase
    function automatic logic at_last(input logic [CNT_W-1:0] cnt,
                                     input int               n);
        return cnt == CNT_W'(n - 1);
    endfunction : at_last

    // ========================================================
    // Sequencer
    assign req_ready = (state_ff == ST_IDLE);

    // RL24 single grade constants
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    cnt_ff <= '0;
                    if (req_valid)
                        state_ff <= req_write ? ST_WRITE : ST_READ;
                end
                // RL9 read cycle length
                ST_READ: begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                    if (at_last(cnt_ff, READ_CYC)) begin
                        state_ff <= ST_FLOAT;
                        cnt_ff   <= '0;
                    end
                end
                // RL16 select spans pulse
                // RL17 address before end
                // RL20 data before end
                // RL19 write pulse width
                ST_WRITE: begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                    if (at_last(cnt_ff, WP_CYC)) begin
                        state_ff <= ST_HOLD;
                        cnt_ff   <= '0;
                    end
                end
                // RL15 write cycle length
                // RL21 data and address hold
                ST_HOLD: state_ff <= ST_IDLE;
                // RL14 wait for output float
                ST_FLOAT: begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                    if (at_last(cnt_ff, FLOAT_CYC))
                        state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ========================================================
    // Pins, all from flip-flops
    // RL1 full word address
    // RL8 address held whole cycle
    // RL5 address moves only while idle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            word_address <= '0;
            data_to_mem  <= 1'b0;
        end else if (state_ff == ST_IDLE && req_valid) begin
            // RL7 address and select together
            word_address <= req_addr;
            data_to_mem  <= req_wdata;
        end
    end

    // RL2 select high outside a cycle
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            select_n   <= 1'b1;
            write_en_n <= 1'b1;
        end else begin
            // RL18 strobes start with address
            select_n   <= !(state_ff == ST_IDLE && req_valid) &&
                          !(state_ff == ST_READ &&
                            !at_last(cnt_ff, READ_CYC)) &&
                          !(state_ff == ST_WRITE &&
                            !at_last(cnt_ff, WP_CYC));
            // RL4 write strobe low for store
            write_en_n <= !((state_ff == ST_IDLE && req_valid &&
                             req_write) ||
                            (state_ff == ST_WRITE &&
                             !at_last(cnt_ff, WP_CYC)));
        end
    end

    // ========================================================
    // Read capture at end of access
    // RL3 sample while reading
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            // RL10 sample after access time
            if (state_ff == ST_READ && at_last(cnt_ff, ACC_CYC)) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_from_mem;
            end
        end
    end

    // ========================================================
    // Checks
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence read_start_s;
        state_ff == ST_IDLE && req_valid && !req_write;
    endsequence

    sequence write_end_s;
        $rose(write_en_n);
    endsequence

    // RL9 read select width
    read_width_a: assert property ( // RL9
        read_start_s |=> !select_n [*3] ##1 select_n)
        else $error("read select width wrong");
    // RL19 write pulse width
    write_pulse_a: assert property ( // RL19
        $fell(write_en_n) |-> !write_en_n [*2])
        else $error("write pulse too short");
    // RL5 address stable under strobes
    addr_stable_a: assert property ( // RL5
        (!select_n && !write_en_n && !$past(write_en_n)) |->
            $stable(word_address))
        else $error("address moved during write");
    // RL2 idle keeps select high
    idle_sel_a: assert property ( // RL2
        state_ff == ST_IDLE |-> select_n)
        else $error("select low while idle");
    // RL21 data held past write end
    data_hold_a: assert property ( // RL21
        write_end_s |-> $stable(data_to_mem))
        else $error("write data changed at end");
    // RL10 response after access
    rsp_time_a: assert property ( // RL10
        read_start_s |-> !rsp_valid [*4] ##1 rsp_valid)
        else $error("read response not on time");
    // RL16 select covers write
    sel_write_a: assert property ( // RL16
        !write_en_n |-> !select_n)
        else $error("write without select");
    // RL14 float gap after read
    float_gap_a: assert property ( // RL14
        (state_ff == ST_FLOAT && $rose(select_n)) |-> !req_ready [*2])
        else $error("no float gap after read");
    // RL3 read keeps write strobe high
    read_strobe_a: assert property ( // RL3
        read_start_s |=> write_en_n [*3])
        else $error("write strobe low during read");
    // RL7 address on pins with select
    read_addr_a: assert property ( // RL7
        read_start_s |=> word_address == $past(req_addr))
        else $error("read address not on pins");
    // RL15 write cycle length
    write_cycle_a: assert property ( // RL15
        $fell(write_en_n) |=> $stable(word_address) [*3])
        else $error("write cycle too short");
    // RL17 address valid before write end
    addr_setup_a: assert property ( // RL17
        write_end_s |-> word_address == $past(word_address, 2))
        else $error("address late for write end");
    // RL20 data valid before write end
    data_setup_a: assert property ( // RL20
        write_end_s |-> data_to_mem == $past(data_to_mem, 2))
        else $error("write data late for write end");

endmodule : sram_bit_ctrl

// ==== bench/sram_bit_model.sv ====
// Behavioural 64K x 1 static memory standing at the controller's pins.
// Assumes the pins are wired straight across; the memory has no clock.
`timescale 1ns/100ps
module sram_bit_model #(
    parameter int ACC_NS = 20
) (
    // Memory pins
    input  wire logic [15:0] word_address,
    input  wire logic        select_n,
    input  wire logic        write_en_n,
    input  wire logic        data_to_mem,
    output logic             data_from_mem
);
    logic mem [0:65535];
    initial data_from_mem = 1'b0;
    // ========================================================
    // Storage
    // store while both low
    always @(select_n, write_en_n, word_address, data_to_mem) begin
        if (!select_n && !write_en_n) begin
            mem[word_address] = data_to_mem;
        end
    end
    // ========================================================
    // Read path
    // output timing
    // Floating output shows the inverse of the old bit, never a held copy
    always @(select_n, write_en_n, word_address) begin
        data_from_mem <= #5 ~data_from_mem;
        if (!select_n && write_en_n) begin
            data_from_mem <= #(ACC_NS) mem[word_address];
        end
    end
endmodule : sram_bit_model

// ==== bench/testbench.sv ====
// Self-checking bench for the single-bit memory controller.
// Assumes the behavioural memory model sits on the far side.
`timescale 1ns/100ps
module testbench;
    import sram_timing_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic req_wdata = 1'b0, req_ready, rsp_valid, rsp_rdata;
    logic select_n, write_en_n, data_to_mem, data_from_mem, got;
    logic [ADDR_W-1:0] req_addr = '0, word_address;
    int num_errors = 0, n_compared = 0;
    logic [17:0] rows [4] = '{18'h3_0000, 18'h3_FFFF, 18'h2_A5A5, 18'h1_FFFF};
    always #5 sys_clk = ~sys_clk;
    sram_bit_ctrl i_sram_bit_ctrl (.sys_clk(sys_clk), .rstn(rstn),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .word_address(word_address), .select_n(select_n),
        .write_en_n(write_en_n), .data_to_mem(data_to_mem),
        .data_from_mem(data_from_mem));
    sram_bit_model #(.ACC_NS(25)) i_sram_bit_model (
        .word_address(word_address), .select_n(select_n),
        .write_en_n(write_en_n), .data_to_mem(data_to_mem),
        .data_from_mem(data_from_mem));
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // Bounded wait at falling edges; a lapse ends the run
    task automatic wait_for(ref logic sig, input int lim, output int n);
        for (n = 0; sig !== 1'b1; n++) begin
            if (n > lim) begin
                num_errors++;
                final_report();
            end
            @(negedge sys_clk);
        end
    endtask : wait_for
    task automatic op(input logic w, input logic [15:0] a, input logic d);
        int n;
        @(negedge sys_clk);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        wait_for(req_ready, 20, n);
        @(negedge sys_clk);
        req_valid = 1'b0;
        check("ready", req_ready, 1'b0); // busy after taking
        check("addr", word_address, a); // address on pins
        check("select", select_n, 1'b0); // selected
        check("strobe", write_en_n, !w); // write strobe
        if (w) check("wdata", data_to_mem, d); // data with strobe
        else begin
            wait_for(rsp_valid, 8, n);
            check("latency", 16'(n), 16'(ACC_CYC)); // answer timing
            got = rsp_rdata;
        end
    endtask : op
    initial begin
        repeat (3) @(negedge sys_clk);
        check("rst select", select_n, 1'b1); // idle deselected
        check("rst strobe", write_en_n, 1'b1); // idle strobe high
        rstn = 1'b1;
        foreach (rows[i]) begin
            op(1'b1, rows[i][15:0], rows[i][16]);
            op(1'b0, rows[i][15:0], 1'b0);
            check("rdata", got, rows[i][16]); // read back
            $display("row %0d done", i);
        end
        op(1'b1, 16'h0001, 1'b1);
        op(1'b1, 16'h0001, 1'b0);
        op(1'b0, 16'h0001, 1'b0);
        check("overwrite", got, 1'b0); // back to back
        op(1'b0, 16'h0000, 1'b0);
        rstn = 1'b0;
        @(negedge sys_clk);
        check("mid rst", select_n, 1'b1); // reset deselects
        check("mid rst ready", req_ready, 1'b1); // idle after reset
        rstn = 1'b1;
        op(1'b0, 16'hFFFF, 1'b0);
        check("after rst", got, 1'b1); // data kept
        $display("awkward cases done");
        final_report();
    end
endmodule : testbench
